// >>> rtl/spm_monitor.sv
`timescale 1ns/10ps
`include "spm_regs.svh"

// How it works
// - Run all five self-tests at startup, then all but consistency under 500 ms.
// - Pulse the brake output off for 1 ms every 900 ms.
// - Toggle the torque-off test output every 1000 ms, none at startup.
// - Pulse high safe outputs low every 1100 ms.
// - Never start a brake test; flag overdue when the interval expires.
// - Channel disagreement over 50 ms raises an input or output fault.
// - Encoder position mismatch raises encoder fault and torque-off within 10 ms.
// - Invalid sine/cosine raises encoder fault and torque-off within 5 ms.
// - Brake pulse error raises brake fault, controlled stop, torque-off within 5 s.
module spm_monitor #(
    parameter int NI          = 4,
    parameter int NO          = 2,
    parameter int ENC_W       = 32,
    parameter int BT_W        = 32,
    parameter int TICK_CYCLES = `SPM_TICK_NS / `SPM_CLK_NS
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    // Safe digital inputs, two channels, from pins
    input  wire logic [NI-1:0]         din_a,
    input  wire logic [NI-1:0]         din_b,
    // Safe digital outputs: command, pin drive and pin feedback
    input  wire logic [NO-1:0]         dout_req,
    output logic      [NO-1:0]         dout_a,
    output logic      [NO-1:0]         dout_b,
    input  wire logic [NO-1:0]         dout_fb_a,
    input  wire logic [NO-1:0]         dout_fb_b,
    // Brake driver
    input  wire logic                  brake_cmd,
    output logic                       brake_out,
    input  wire logic                  brake_fb,
    // Torque-off path
    output logic                       torque_off_test,
    output logic                       torque_off_state,
    output logic                       controlled_stop_then_off,
    input  wire logic                  stop_done,
    // Self-test engines
    output logic                       st_start,
    output logic [`SPM_NTEST-1:0]      st_sel,
    input  wire logic                  st_done,
    input  wire logic [`SPM_NTEST-1:0] st_fail,
    // Encoder checks
    input  wire logic                  enc_cmp_valid,
    input  wire logic [ENC_W-1:0]      enc_pos_a,
    input  wire logic [ENC_W-1:0]      enc_pos_b,
    input  wire logic                  sincos_invalid,
    // Brake test supervision
    input  wire logic [BT_W-1:0]       brake_test_interval,
    input  wire logic                  brake_test_done,
    output logic                       brake_test_overdue,
    // Faults
    input  wire logic                  fault_clear,
    output spm_pkg::spm_fault_t        fault
);

    localparam int NC = NI + NO;
    localparam int RW = 2 * NC + 1;
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int MW = `SPM_MS_W;

    generate
        // The brake feedback crosses two flops, so a pulse must outlast them.
        if (NI < 1 || NO < 1 || TICK_CYCLES < 3 || ENC_W < 1 || BT_W < 1) begin
            $error("spm_monitor: parameter out of range");
        end
    endgenerate

    typedef struct packed {
        spm_pkg::spm_st_t          st;
        logic                      boot;
        logic [MW-1:0]             st_cnt;
        logic                      st_start;
        logic [`SPM_NTEST-1:0]     st_sel;
        logic [TW-1:0]             tick_cnt;
        logic                      tick;
        logic [RW-1:0]             s1;
        logic [RW-1:0]             s2;
        logic [NC-1:0][MW-1:0]     dc;
        logic [MW-1:0]             bk_cnt;
        logic                      bk_pulse;
        logic                      brake_out;
        logic [MW-1:0]             to_cnt;
        logic                      to_test;
        logic [MW-1:0]             do_cnt;
        logic                      do_pulse;
        logic [NO-1:0]             dout_a;
        logic [NO-1:0]             dout_b;
        logic [BT_W-1:0]           bt_cnt;
        logic                      bt_overdue;
        logic [MW-1:0]             stop_cnt;
        logic                      stop_req;
        logic                      torque_off;
        spm_pkg::spm_fault_t       flt;
    } spm_state_t;

    spm_state_t            s;
    spm_state_t            next_s;
    logic [NC-1:0][MW-1:0] next_dc;
    logic [NC-1:0]         trip;
    logic [RW-1:0]         raw;

    // Channel A sits in the low half, channel B in the next, brake last.
    assign raw = {brake_fb, dout_fb_b, din_b, dout_fb_a, din_a};

    // Discrepancy timers: reset on agreement, saturate once past the limit.
    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++) begin : g_disc
            always_comb begin
                if (s.s2[gi] == s.s2[NC + gi]) begin
                    next_dc[gi] = '0;
                end else if (s.tick && s.dc[gi] <= MW'(`SPM_DISC_MS)) begin
                    next_dc[gi] = s.dc[gi] + MW'(1);
                end else begin
                    next_dc[gi] = s.dc[gi];
                end
            end
            assign trip[gi] = s.dc[gi] > MW'(`SPM_DISC_MS);
        end
    endgenerate

    always_comb begin
        next_s          = s;
        next_s.st_start = 1'b0;
        next_s.tick     = 1'b0;
        next_s.s1       = raw;
        next_s.s2       = s.s1;
        next_s.dc       = next_dc;

        // Common millisecond tick.
        if (s.tick_cnt == TW'(TICK_CYCLES - 1)) begin
            next_s.tick_cnt = '0;
            next_s.tick     = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + TW'(1);
        end

        // Sticky faults: a clear in the same cycle as a new fault loses.
        if (fault_clear) begin
            next_s.flt = '0;
        end

        // Self-test scheduler; the period runs from one launch to the next.
        if (s.tick && s.st_cnt != MW'(`SPM_SELFTEST_MS)) begin
            next_s.st_cnt = s.st_cnt + MW'(1);
        end
        unique case (s.st)
            spm_pkg::SPM_ST_LAUNCH: begin
                next_s.st_start = 1'b1;
                next_s.st_sel   = s.boot ? `SPM_SEL_STARTUP
                                         : `SPM_SEL_PERIODIC;
                next_s.st_cnt   = '0;
                next_s.st       = spm_pkg::SPM_ST_WAIT;
            end
            spm_pkg::SPM_ST_WAIT: begin
                if (st_done) begin
                    if (|(st_fail & s.st_sel)) begin
                        next_s.flt.selftest = 1'b1;
                    end
                    next_s.boot = 1'b0;
                    next_s.st   = spm_pkg::SPM_ST_IDLE;
                end else if (s.st_cnt == MW'(`SPM_SELFTEST_MS)) begin
                    // An engine that never answers must not stall the cycle.
                    next_s.flt.selftest = 1'b1;
                    next_s.boot         = 1'b0;
                    next_s.st           = spm_pkg::SPM_ST_LAUNCH;
                end
            end
            spm_pkg::SPM_ST_IDLE: begin
                if (s.st_cnt == MW'(`SPM_SELFTEST_MS)) begin
                    next_s.st = spm_pkg::SPM_ST_LAUNCH;
                end
            end
        endcase

        // Brake test pulse; current still flowing at its end is a fault.
        if (s.tick) begin
            if (s.bk_cnt == MW'(`SPM_BRAKE_PERIOD_MS - 1)) begin
                next_s.bk_cnt = '0;
            end else begin
                next_s.bk_cnt = s.bk_cnt + MW'(1);
            end
            next_s.bk_pulse = next_s.bk_cnt < MW'(`SPM_BRAKE_PULSE_MS);
            if (s.bk_pulse && !next_s.bk_pulse && brake_cmd && s.s2[2*NC]) begin
                next_s.flt.brake = 1'b1;
            end
        end
        next_s.brake_out = brake_cmd && !next_s.bk_pulse;

        // Torque-off circuit exercise, first change one period after start.
        if (s.tick) begin
            if (s.to_cnt == MW'(`SPM_TOFF_PERIOD_MS - 1)) begin
                next_s.to_cnt  = '0;
                next_s.to_test = !s.to_test;
            end else begin
                next_s.to_cnt = s.to_cnt + MW'(1);
            end
        end

        // Safe output test pulse; only outputs that are high see it.
        if (s.tick) begin
            if (s.do_cnt == MW'(`SPM_DOUT_PERIOD_MS - 1)) begin
                next_s.do_cnt = '0;
            end else begin
                next_s.do_cnt = s.do_cnt + MW'(1);
            end
            next_s.do_pulse = next_s.do_cnt < MW'(`SPM_DOUT_PULSE_MS);
        end
        next_s.dout_a = dout_req & {NO{!next_s.do_pulse}};
        next_s.dout_b = dout_req & {NO{!next_s.do_pulse}};

        // Channel discrepancy faults.
        if (|trip[NI-1:0]) begin
            next_s.flt.din = 1'b1;
        end
        if (|trip[NC-1:NI]) begin
            next_s.flt.dout = 1'b1;
        end

        // Encoder checks react in the next cycle, far inside both limits.
        if (enc_cmp_valid && enc_pos_a != enc_pos_b) begin
            next_s.flt.enc = 1'b1;
        end
        if (sincos_invalid) begin
            next_s.flt.enc = 1'b1;
        end

        // Brake-test interval supervision; the test itself is not started.
        if (brake_test_done) begin
            next_s.bt_cnt     = '0;
            next_s.bt_overdue = 1'b0;
        end else begin
            if (s.tick && s.bt_cnt != brake_test_interval) begin
                next_s.bt_cnt = s.bt_cnt + BT_W'(1);
            end
            if (s.bt_cnt == brake_test_interval) begin
                next_s.bt_overdue = 1'b1;
            end
        end

        // Controlled stop on brake fault, torque-off once stopped or timed out.
        next_s.stop_req = next_s.flt.brake;
        if (!s.stop_req) begin
            next_s.stop_cnt = '0;
        end else if (s.tick && s.stop_cnt != MW'(`SPM_STOP_LIMIT_MS)) begin
            next_s.stop_cnt = s.stop_cnt + MW'(1);
        end
        next_s.torque_off = next_s.flt.enc || next_s.flt.din
                         || next_s.flt.dout || next_s.flt.selftest
                         || (s.stop_req && (stop_done
                             || s.stop_cnt == MW'(`SPM_STOP_LIMIT_MS)));
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s          <= '0;
            s.st       <= spm_pkg::SPM_ST_LAUNCH;
            s.boot     <= 1'b1;
            s.bk_cnt   <= MW'(`SPM_BRAKE_PULSE_MS);
            s.do_cnt   <= MW'(`SPM_DOUT_PULSE_MS);
        end else begin
            s <= next_s;
        end
    end

    assign dout_a                   = s.dout_a;
    assign dout_b                   = s.dout_b;
    assign brake_out                = s.brake_out;
    assign torque_off_test          = s.to_test;
    assign torque_off_state         = s.torque_off;
    assign controlled_stop_then_off = s.stop_req;
    assign st_start                 = s.st_start;
    assign st_sel                   = s.st_sel;
    assign brake_test_overdue       = s.bt_overdue;
    assign fault                    = s.flt;

endmodule

// >>> pkg/spm_regs.svh
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// Clock and tick base, in their own units.
`define SPM_CLK_NS          8
`define SPM_TICK_NS         1000000

// Schedules and limits in milliseconds, then the counter width in bits.
`define SPM_SELFTEST_MS     400
`define SPM_BRAKE_PERIOD_MS 900
`define SPM_BRAKE_PULSE_MS  1
`define SPM_TOFF_PERIOD_MS  1000
`define SPM_DOUT_PERIOD_MS  1100
`define SPM_DOUT_PULSE_MS   1
`define SPM_DISC_MS         50
`define SPM_STOP_LIMIT_MS   5000
`define SPM_MS_W            16

// Self-test select bits.
`define SPM_NTEST           5
`define SPM_T_CPU           0
`define SPM_T_RAM           1
`define SPM_T_PARAM_CRC     2
`define SPM_T_PARAM_CONS    3
`define SPM_T_PROG_CRC      4
`define SPM_SEL_STARTUP     5'h1F
`define SPM_SEL_PERIODIC    5'h17

`endif

// >>> pkg/spm_pkg.sv
package spm_pkg;

    typedef enum logic [2:0] {
        SPM_ST_LAUNCH = 3'h1,
        SPM_ST_WAIT   = 3'h2,
        SPM_ST_IDLE   = 3'h4
    } spm_st_t;

    typedef struct packed {
        logic selftest;
        logic din;
        logic dout;
        logic enc;
        logic brake;
    } spm_fault_t;

endpackage

// >>> tb/spm_props.sv
`timescale 1ns/10ps
module spm_props #(
    parameter int NO    = 2,
    parameter int ENC_W = 32
) (
    // Clock and reset
    input wire logic                mclk,
    input wire logic                rstn,
    // Outputs and brake
    input wire logic [NO-1:0]       dout_req,
    input wire logic [NO-1:0]       dout_a,
    input wire logic                brake_cmd,
    input wire logic                brake_out,
    // Torque-off path
    input wire logic                torque_off_state,
    input wire logic                controlled_stop_then_off,
    input wire logic                stop_done,
    // Self-test and encoder
    input wire logic                st_start,
    input wire logic [4:0]          st_sel,
    input wire logic                enc_cmp_valid,
    input wire logic [ENC_W-1:0]    enc_pos_a,
    input wire logic [ENC_W-1:0]    enc_pos_b,
    input wire logic                sincos_invalid,
    // Brake test and faults
    input wire logic                brake_test_done,
    input wire logic                brake_test_overdue,
    input wire spm_pkg::spm_fault_t fault
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_enc_pos;
        enc_cmp_valid && enc_pos_a != enc_pos_b |=> fault.enc && torque_off_state;
    endproperty
    a_enc_pos: assert property (p_enc_pos) else $error("encoder mismatch ignored");
    property p_sincos;
        sincos_invalid |=> fault.enc && torque_off_state;
    endproperty
    a_sincos: assert property (p_sincos) else $error("sincos fault ignored");
    property p_st_sel;
        st_start |-> st_sel == 5'h1F || st_sel == 5'h17;
    endproperty
    a_st_sel: assert property (p_st_sel) else $error("bad self-test select");
    property p_st_pulse;
        st_start |=> !st_start [*8];
    endproperty
    a_st_pulse: assert property (p_st_pulse) else $error("launch too soon");
    property p_brake_off;
        !brake_cmd |=> !brake_out;
    endproperty
    a_brake_off: assert property (p_brake_off) else $error("brake driven");
    property p_brake_pulse;
        $fell(brake_out) && brake_cmd && $past(brake_cmd) |-> !brake_out [*3];
    endproperty
    a_brake_pulse: assert property (p_brake_pulse) else $error("short pulse");
    property p_dout_off;
        dout_req == '0 |=> dout_a == '0;
    endproperty
    a_dout_off: assert property (p_dout_off) else $error("output driven");
    property p_overdue_clr;
        brake_test_done |=> !brake_test_overdue;
    endproperty
    a_overdue_clr: assert property (p_overdue_clr) else $error("overdue kept");
    property p_stop;
        $rose(fault.brake) |-> controlled_stop_then_off;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop request");
    property p_stop_off;
        controlled_stop_then_off && stop_done |=> torque_off_state;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("no torque off");
endmodule
bind spm_monitor spm_props #(.NO(NO), .ENC_W(ENC_W)) u_props (.mclk, .rstn,
    .dout_req, .dout_a, .brake_cmd, .brake_out, .torque_off_state,
    .controlled_stop_then_off, .stop_done, .st_start, .st_sel, .enc_cmp_valid,
    .enc_pos_a, .enc_pos_b, .sincos_invalid, .brake_test_done,
    .brake_test_overdue, .fault);

// >>> tb/spm_partner.sv
`timescale 1ns/10ps
module spm_partner (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // Self-test engines
    input wire logic        st_start,
    input wire logic        st_bad,
    output logic            st_done,
    output logic [4:0]      st_fail,
    // Feedback pins
    input wire logic [1:0]  dout_a,
    input wire logic [1:0]  dout_b,
    input wire logic        brake_out,
    input wire logic        brake_stuck,
    output logic [1:0]      dout_fb_a,
    output logic [1:0]      dout_fb_b,
    output logic            brake_fb,
    // Controller side of the brake test
    input wire logic        brake_test_overdue,
    output logic            brake_test_done
);
    logic [3:0] dly;
    // Receivers see the test pulses but treat them as no change of state.
    assign dout_fb_a = dout_a;
    assign dout_fb_b = dout_b;
    // A stuck driver keeps current flowing through the test pulse.
    assign brake_fb = brake_out | brake_stuck;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dly <= 4'h0;
            st_done <= 1'b0;
            st_fail <= 5'h00;
            brake_test_done <= 1'b0;
        end else begin
            dly <= {dly[2:0], st_start};
            st_done <= dly[3];
            st_fail <= {5{st_bad & dly[3]}};
            brake_test_done <= brake_test_overdue & ~brake_test_done;
        end
    end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic mclk, rstn, brake_cmd, brake_out, brake_fb, torque_off_test;
    logic torque_off_state, controlled_stop_then_off, stop_done, st_start;
    logic st_done, enc_cmp_valid, sincos_invalid, brake_test_done;
    logic brake_test_overdue, fault_clear, st_bad, brake_stuck;
    logic [3:0] din_a, din_b;
    logic [1:0] dout_req, dout_a, dout_b, dout_fb_a, dout_fb_b;
    logic [4:0] st_sel, st_fail;
    logic [31:0] enc_pos_a, enc_pos_b, brake_test_interval;
    spm_pkg::spm_fault_t fault;
    int bad_count = 0, n_tests = 0, cyc = 0, c1, c2;
    spm_monitor #(.TICK_CYCLES(4)) DUT (.mclk, .rstn, .din_a, .din_b,
        .dout_req, .dout_a, .dout_b, .dout_fb_a, .dout_fb_b, .brake_cmd,
        .brake_out, .brake_fb, .torque_off_test, .torque_off_state,
        .controlled_stop_then_off, .stop_done, .st_start, .st_sel, .st_done,
        .st_fail, .enc_cmp_valid, .enc_pos_a, .enc_pos_b, .sincos_invalid,
        .brake_test_interval, .brake_test_done, .brake_test_overdue,
        .fault_clear, .fault);
    spm_partner u_partner (.mclk, .rstn, .st_start, .st_bad, .st_done,
        .st_fail, .dout_a, .dout_b, .brake_out, .brake_stuck, .dout_fb_a,
        .dout_fb_b, .brake_fb, .brake_test_overdue, .brake_test_done);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task print_verdict;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            print_verdict;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    function logic sig(input int w);
        case (w)
            0: return brake_out;
            1: return dout_a[0];
            2: return ~st_start;
            3: return ~brake_test_overdue;
            default: return ~fault.brake;
        endcase
    endfunction
    // Counts cycles until the watched signal reads low.
    task wait_low(input int w, output int n);
        n = 0;
        while (sig(w) !== 1'b0 && n < 6000) begin
            step(1);
            n++;
        end
    endtask
    // Low time of one pulse into c1, the high gap to the next into c2.
    task pulse(input int w);
        wait_low(w, c1);
        c1 = 0;
        while (sig(w) === 1'b0) begin
            step(1);
            c1++;
        end
        wait_low(w, c2);
    endtask
    task t_selftest;
        wait_low(2, c1);
        chk(st_sel, 5'h1F, "startup select");
        pulse(2);
        chk(st_sel, 5'h17, "periodic select");
        chk(c2 < 2000, 1, "self-test period");
        chk(fault, 5'h00, "spurious fault");
        chk(torque_off_test, 0, "no startup toggle");
    endtask
    task t_overdue;
        pulse(3);
        chk(c2 >= 116 && c2 <= 128, 1, "overdue gap");
    endtask
    task clear;
        fault_clear = 1'b1;
        step(1);
        fault_clear = 1'b0;
        step(1);
        chk(fault, 5'h00, "fault clear");
    endtask
    task t_disc;
        din_b = 4'h7;
        step(180);
        chk(fault.din, 0, "early din fault");
        step(40);
        chk(fault.din, 1, "din fault");
        din_b = 4'hF;
        // Let the agreement pass the synchroniser before the clear.
        step(4);
        clear;
    endtask
    task t_enc;
        enc_pos_b = 32'h0000_0001;
        enc_cmp_valid = 1'b1;
        step(1);
        enc_cmp_valid = 1'b0;
        step(1);
        chk({fault.enc, torque_off_state}, 2'h3, "enc mismatch");
        clear;
        sincos_invalid = 1'b1;
        step(1);
        sincos_invalid = 1'b0;
        step(1);
        chk({fault.enc, torque_off_state}, 2'h3, "sincos");
        clear;
    endtask
    task t_off;
        {brake_cmd, dout_req} = 3'h0;
        step(2);
        chk(brake_out, 0, "brake driven while off");
        chk({dout_a, dout_b}, 4'h0, "output driven while off");
        {brake_cmd, dout_req} = 3'h7;
        step(2);
        chk(brake_out, 1, "brake not driven");
        chk({dout_a, dout_b}, 4'hF, "output not driven");
    endtask
    task t_st_fail;
        st_bad = 1'b1;
        wait_low(2, c1);
        step(8);
        st_bad = 1'b0;
        chk(fault.selftest, 1, "self-test failure");
        clear;
    endtask
    task t_toff;
        logic v;
        v = torque_off_test;
        c1 = 0;
        while (torque_off_test === v && c1 < 6000) begin
            step(1);
            c1++;
        end
        v = torque_off_test;
        c2 = 0;
        while (torque_off_test === v && c2 < 6000) begin
            step(1);
            c2++;
        end
        chk(c2, 4000, "torque-off test period");
    endtask
    task t_brake_fault;
        brake_stuck = 1'b1;
        wait_low(4, c1);
        chk(controlled_stop_then_off, 1, "stop request");
        chk(torque_off_state, 0, "early torque off");
        stop_done = 1'b1;
        step(2);
        chk(torque_off_state, 1, "torque off");
    endtask
    initial begin
        {rstn, fault_clear, st_bad, brake_stuck, stop_done} = 5'h00;
        {enc_cmp_valid, sincos_invalid, enc_pos_a, enc_pos_b} = '0;
        {brake_cmd, dout_req, din_a, din_b} = 11'h7FF;
        brake_test_interval = 32'h0000_001E;
        step(6);
        rstn = 1'b1;
        t_selftest;
        t_overdue;
        pulse(0);
        chk(c1, 4, "brake pulse width");
        chk(c2, 3596, "brake pulse gap");
        pulse(1);
        chk(c1, 4, "output pulse width");
        chk(c2, 4396, "output pulse gap");
        chk(dout_b, 2'h0, "output B pulse");
        t_disc;
        t_enc;
        t_off;
        t_st_fail;
        t_brake_fault;
        t_toff;
        print_verdict;
    end
endmodule
